// *** core/mfs_aligner.sv ***
// Local multiframe counter with SYSREF sampling, period check and APB registers
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Behaviour
// R1 - Counter period is F times K over four
// R2 - Count zero to period minus one, wrap
// R3 - SYSREF rising edge clears counter when enabled
// R4 - SYSREF sampled on link clock, low to high
// R5 - Edge needs two consecutive high samples
// R6 - Software keeps K between 1 and 32
// R7 - Software keeps multiframe 17 to 1024 octets
// R8 - Software keeps F times K multiple of four
// R9 - One-shot bit resets once, then self-clears
// R10 - One-shot bit holds code group sync exit
// R11 - Continuous bit resets on every edge
// R12 - Continuous bit checks SYSREF spacing, flags error
// R13 - Continuous bit alone does not hold sync
// R14 - Both bits: reset, hold, and check
// R15 - SYSREF rate is multiframe rate over integer
// R16 - Link and frame clocks share one PLL
// R17 - Control bits crossing domains are synchronised
// R18 - Link clock is the single timing reference
// R19 - Subclass 0 ignores SYSREF entirely
// R20 - With F of 4 PHY clock may serve
// R21 - Prefer at least 32 octets per multiframe
// R22 - Four octets per link clock cycle
module mfs_aligner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic sysref,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [10:0] mf_count,
    output logic mf_boundary,
    output logic cgs_hold,
    output logic period_err
);

    mfs_pkg::mfs_state_type st_q;
    mfs_pkg::mfs_state_type st_d;
    logic sysref_edge;
    logic edge_use;
    logic [10:0] cnt_last;
    logic apb_first;
    logic apb_done;
    logic hit;

    // Register map, one aligned word each:
    //   control: one-shot, continuous and subclass 1 bits
    //   config: F minus one and K minus one
    //   status: sticky period error (write one clears), aligned, live count
    // Control bits are plain flops on pclk; the bus shares the link clock,
    // so a slower management clock would need a handshake here instead.
    // Unmapped addresses answer with an error and read as zero.

    // Last count of a multiframe from the F and K fields
    function automatic logic [10:0] mf_last(input logic [7:0] f_m1, input logic [4:0] k_m1);
        logic [14:0] octets;
        octets = 15'({7'h00, f_m1} + 15'h0001) * 15'({10'h000, k_m1} + 15'h0001);
        if (octets < 15'(mfs_pkg::MFS_OCTETS_PER_CLK)) begin
            mf_last = 11'h000;
        end else begin
            mf_last = 11'((octets >> 2) - 15'h0001); // R1 R22
        end
    endfunction : mf_last

    // Edge seen once the settled level was low and two samples agree high
    assign sysref_edge = !st_q.lvl && st_q.sync[1] && st_q.sync[2]; // R4 R5
    // Subclass 0 never lets SYSREF touch the counter
    assign edge_use = sysref_edge && st_q.ctrl.sub1
        && (st_q.ctrl.singledet || st_q.ctrl.alwayson); // R3 R11 R14 R19
    assign cnt_last = mf_last(st_q.f_m1, st_q.k_m1);
    // Registers share pclk with the link logic, so no crossing is needed here
    assign apb_first = psel && penable && !st_q.pready; // R17 R18
    assign apb_done = psel && penable && st_q.pready;
    assign hit = (paddr == mfs_pkg::MFS_CTRL_OFS) || (paddr == mfs_pkg::MFS_CFG_OFS)
        || (paddr == mfs_pkg::MFS_STATUS_OFS);

    // Next-state logic for the whole block
    always_comb begin
        st_d = st_q;
        // Three-stage pin synchroniser; first stage only feeds the second
        st_d.sync = {st_q.sync[1:0], sysref};
        if (st_q.sync[1] == st_q.sync[2]) begin
            st_d.lvl = st_q.sync[2]; // R5
        end

        // Multiframe counter
        if (edge_use) begin
            st_d.cnt = 11'h000; // R3 R11
            st_d.aligned = 1'b1;
        end else if (st_q.cnt >= cnt_last) begin
            st_d.cnt = 11'h000; // R2
        end else begin
            st_d.cnt = st_q.cnt + 11'h001; // R1
        end
        st_d.boundary = (st_d.cnt == 11'h000); // R2

        // Period check: an aligned edge must land on the last count
        if (edge_use && st_q.ctrl.alwayson && st_q.aligned && (st_q.cnt != cnt_last)) begin
            st_d.err = 1'b1; // R12 R14
        end

        // APB: one wait state, read data prepared in the first access cycle
        st_d.pready = apb_first;
        if (apb_first) begin
            st_d.pslverr = !hit;
            st_d.prdata = 32'h0000_0000;
            case (paddr)
                mfs_pkg::MFS_CTRL_OFS: begin
                    st_d.prdata[mfs_pkg::MFS_CTRL_SINGLE_BIT] = st_q.ctrl.singledet;
                    st_d.prdata[mfs_pkg::MFS_CTRL_ALWAYS_BIT] = st_q.ctrl.alwayson;
                    st_d.prdata[mfs_pkg::MFS_CTRL_SUB1_BIT] = st_q.ctrl.sub1;
                end
                mfs_pkg::MFS_CFG_OFS: begin
                    st_d.prdata[mfs_pkg::MFS_CFG_F_LSB +: 8] = st_q.f_m1;
                    st_d.prdata[mfs_pkg::MFS_CFG_K_LSB +: 5] = st_q.k_m1;
                end
                mfs_pkg::MFS_STATUS_OFS: begin
                    st_d.prdata[mfs_pkg::MFS_STAT_ERR_BIT] = st_q.err;
                    st_d.prdata[mfs_pkg::MFS_STAT_ALIGNED_BIT] = st_q.aligned;
                    st_d.prdata[mfs_pkg::MFS_STAT_CNT_LSB +: 11] = st_q.cnt;
                end
                default: begin
                    st_d.prdata = 32'h0000_0000;
                end
            endcase
        end

        // Writes take effect on the completing edge
        if (apb_done && pwrite) begin
            case (paddr)
                mfs_pkg::MFS_CTRL_OFS: begin
                    st_d.ctrl.singledet = pwdata[mfs_pkg::MFS_CTRL_SINGLE_BIT];
                    st_d.ctrl.alwayson = pwdata[mfs_pkg::MFS_CTRL_ALWAYS_BIT];
                    st_d.ctrl.sub1 = pwdata[mfs_pkg::MFS_CTRL_SUB1_BIT];
                end
                mfs_pkg::MFS_CFG_OFS: begin
                    st_d.f_m1 = pwdata[mfs_pkg::MFS_CFG_F_LSB +: 8];
                    st_d.k_m1 = pwdata[mfs_pkg::MFS_CFG_K_LSB +: 5];
                end
                mfs_pkg::MFS_STATUS_OFS: begin
                    // Write one to clear; a fresh error in the same cycle wins
                    if (pwdata[mfs_pkg::MFS_STAT_ERR_BIT] && !st_d.err) begin
                        st_d.err = 1'b0;
                    end else if (pwdata[mfs_pkg::MFS_STAT_ERR_BIT]
                        && !(edge_use && st_q.ctrl.alwayson && st_q.aligned
                        && (st_q.cnt != cnt_last))) begin
                        st_d.err = 1'b0;
                    end
                end
                default: begin
                    st_d.err = st_d.err;
                end
            endcase
        end

        // One-shot clears itself after its edge, even against a write
        if (edge_use && st_q.ctrl.singledet) begin
            st_d.ctrl.singledet = 1'b0; // R9
        end
        // Only the one-shot bit holds sync exit, so the race stays open otherwise
        st_d.cgs_hold = st_d.ctrl.singledet && st_d.ctrl.sub1; // R10 R13 R14
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= mfs_pkg::MFS_STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign mf_count = st_q.cnt;
    assign mf_boundary = st_q.boundary;
    assign cgs_hold = st_q.cgs_hold;
    assign period_err = st_q.err;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Counter, edge filter, one-shot, sync hold and period error behaviour
    a_count_wrap: assert property (!edge_use && st_q.cnt == cnt_last |=> st_q.cnt == 11'h000) // R2
        else $error("counter did not wrap at last count");
    a_count_step: assert property (!edge_use && st_q.cnt < cnt_last
        |=> st_q.cnt == $past(st_q.cnt) + 11'h001) // R1
        else $error("counter did not advance by one");
    a_edge_clear: assert property (edge_use |=> st_q.cnt == 11'h000 && st_q.boundary) // R3
        else $error("SYSREF edge did not clear counter");
    a_edge_filter: assert property ($rose(st_q.lvl) |-> $past(st_q.sync[2]) && $past(st_q.sync[1])) // R5
        else $error("level rose without two high samples");
    a_single_once: assert property (edge_use && st_q.ctrl.singledet
        |=> !st_q.ctrl.singledet ##1 !st_q.cgs_hold) // R9
        else $error("one-shot bit not cleared after edge");
    a_cgs_hold: assert property (st_q.ctrl.singledet && st_q.ctrl.sub1 && !edge_use
        |=> st_q.cgs_hold) // R10
        else $error("sync exit not held under one-shot");
    a_always_nohold: assert property (!st_q.ctrl.singledet && !(apb_done && pwrite)
        |=> !st_q.cgs_hold) // R13
        else $error("continuous bit held sync exit");
    a_period_err: assert property (edge_use && st_q.ctrl.alwayson && st_q.aligned
        && st_q.cnt != cnt_last |=> st_q.err [*2]) // R12
        else $error("bad SYSREF spacing not flagged");
    a_sub0_free: assert property (!st_q.ctrl.sub1 && sysref_edge && st_q.cnt < cnt_last
        |=> st_q.cnt == $past(st_q.cnt) + 11'h001) // R19
        else $error("subclass 0 counter disturbed by SYSREF");

    // Synchroniser and edge detector
    a_sync_shift: assert property (1'b1 |=> st_q.sync[2:1] == $past(st_q.sync[1:0])) // R4
        else $error("SYSREF synchroniser did not shift");
    a_edge_single: assert property (sysref_edge |=> !sysref_edge) // R5
        else $error("SYSREF edge lasted more than one cycle");
    a_lvl_hold: assert property (st_q.sync[1] != st_q.sync[2] // R5
        |=> st_q.lvl == $past(st_q.lvl))
        else $error("settled level moved while samples disagreed");
    a_lvl_fall: assert property ($fell(st_q.lvl) // R5
        |-> !$past(st_q.sync[2]) && !$past(st_q.sync[1]))
        else $error("level fell without two low samples");

    // Counter range, boundary flag and alignment
    a_count_range: assert property (!(apb_done && pwrite) && st_q.cnt <= cnt_last // R2
        |=> st_q.cnt <= cnt_last)
        else $error("counter left its period");
    a_count_over: assert property (!edge_use && st_q.cnt > cnt_last // R2
        |=> st_q.cnt == 11'h000)
        else $error("counter above its period did not return to zero");
    a_bound_mid: assert property (st_q.cnt != 11'h000 |-> !st_q.boundary) // R2
        else $error("boundary flag away from count zero");
    a_bound_wrap: assert property (st_q.cnt != 11'h000 ##1 st_q.cnt == 11'h000 // R2
        |-> st_q.boundary)
        else $error("boundary flag missing at count zero");
    a_aligned_set: assert property (edge_use |=> st_q.aligned) // R3
        else $error("aligned flag not set by SYSREF edge");
    a_aligned_keep: assert property (st_q.aligned |=> st_q.aligned) // R3
        else $error("aligned flag dropped");
    a_off_free: assert property (!st_q.ctrl.singledet && !st_q.ctrl.alwayson // R3
        && st_q.cnt < cnt_last |=> st_q.cnt == $past(st_q.cnt) + 11'h001)
        else $error("counter disturbed with SYSREF disabled");
    a_both_reset: assert property (edge_use && st_q.ctrl.singledet && st_q.ctrl.alwayson // R14
        |=> st_q.cnt == 11'h000 && !st_q.ctrl.singledet)
        else $error("both bits set: edge did not realign once");

    // Period error flag
    a_err_sticky: assert property (st_q.err && !(apb_done && pwrite // R12
        && paddr == mfs_pkg::MFS_STATUS_OFS && pwdata[mfs_pkg::MFS_STAT_ERR_BIT])
        |=> st_q.err)
        else $error("period error dropped without a clear");
    a_err_clear: assert property (apb_done && pwrite && !edge_use // R12
        && paddr == mfs_pkg::MFS_STATUS_OFS && pwdata[mfs_pkg::MFS_STAT_ERR_BIT]
        |=> !st_q.err)
        else $error("period error not cleared by write one");
    a_err_quiet: assert property (!st_q.err && !(edge_use && st_q.ctrl.alwayson) // R12
        |=> !st_q.err)
        else $error("period error raised without a SYSREF edge");
    a_err_onbound: assert property (edge_use && st_q.cnt == cnt_last && !st_q.err // R12
        |=> !st_q.err)
        else $error("period error raised by an edge on the boundary");
    a_sub0_noerr: assert property (!st_q.ctrl.sub1 && !st_q.err // R19
        |=> !st_q.err)
        else $error("subclass 0 raised a period error");

    // Code group hold and one-shot bit
    a_hold_match: assert property (st_q.cgs_hold // R10
        == (st_q.ctrl.singledet && st_q.ctrl.sub1))
        else $error("sync hold differs from one-shot and subclass bits");
    a_single_keep: assert property (st_q.ctrl.singledet && !edge_use // R10
        && !(apb_done && pwrite) |=> st_q.ctrl.singledet)
        else $error("one-shot bit lost before its edge");
    a_single_noset: assert property (!st_q.ctrl.singledet && !(apb_done && pwrite) // R9
        |=> !st_q.ctrl.singledet)
        else $error("one-shot bit set without a write");
    a_single_set: assert property (apb_done && pwrite && paddr == mfs_pkg::MFS_CTRL_OFS // R9
        && !edge_use |=> st_q.ctrl.singledet == $past(pwdata[mfs_pkg::MFS_CTRL_SINGLE_BIT]))
        else $error("one-shot bit write lost");
    a_hold_sub0: assert property (!st_q.ctrl.sub1 && !(apb_done && pwrite) // R19
        |=> !st_q.cgs_hold)
        else $error("subclass 0 held sync exit");

    // Register access
    a_apb_wait: assert property (apb_first |=> st_q.pready) // R17
        else $error("no ready after one wait state");
    a_apb_pulse: assert property (st_q.pready |=> !st_q.pready) // R17
        else $error("ready stood longer than one cycle");
    a_apb_idle: assert property (!(psel && penable) |=> !st_q.pready) // R17
        else $error("ready without an access phase");
    a_apb_unmapped: assert property (apb_first && !hit // R17
        |=> st_q.pslverr && st_q.prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_apb_mapped: assert property (apb_first && hit |=> !st_q.pslverr) // R17
        else $error("mapped access refused");
    a_rd_ctrl: assert property (apb_first && paddr == mfs_pkg::MFS_CTRL_OFS // R17
        |=> st_q.prdata[mfs_pkg::MFS_CTRL_SUB1_BIT] == $past(st_q.ctrl.sub1))
        else $error("control read back wrong");
    a_rd_cfg: assert property (apb_first && paddr == mfs_pkg::MFS_CFG_OFS // R1
        |=> st_q.prdata[mfs_pkg::MFS_CFG_K_LSB +: 5] == $past(st_q.k_m1))
        else $error("configuration read back wrong");
    a_rd_count: assert property (apb_first && paddr == mfs_pkg::MFS_STATUS_OFS // R2
        |=> st_q.prdata[mfs_pkg::MFS_STAT_CNT_LSB +: 11] == $past(st_q.cnt))
        else $error("status count read back wrong");
    a_rd_err: assert property (apb_first && paddr == mfs_pkg::MFS_STATUS_OFS // R12
        |=> st_q.prdata[mfs_pkg::MFS_STAT_ERR_BIT] == $past(st_q.err))
        else $error("status error read back wrong");
    a_rd_aligned: assert property (apb_first && paddr == mfs_pkg::MFS_STATUS_OFS // R3
        |=> st_q.prdata[mfs_pkg::MFS_STAT_ALIGNED_BIT] == $past(st_q.aligned))
        else $error("status aligned read back wrong");
    a_wr_cfg: assert property (apb_done && pwrite && paddr == mfs_pkg::MFS_CFG_OFS // R1
        |=> st_q.f_m1 == $past(pwdata[mfs_pkg::MFS_CFG_F_LSB +: 8]))
        else $error("configuration write lost");
    a_wr_k: assert property (apb_done && pwrite && paddr == mfs_pkg::MFS_CFG_OFS // R1
        |=> st_q.k_m1 == $past(pwdata[mfs_pkg::MFS_CFG_K_LSB +: 5]))
        else $error("frame count write lost");
    a_wr_ctrl: assert property (apb_done && pwrite && paddr == mfs_pkg::MFS_CTRL_OFS // R17
        |=> st_q.ctrl.alwayson == $past(pwdata[mfs_pkg::MFS_CTRL_ALWAYS_BIT]))
        else $error("control write lost");
    a_cfg_hold: assert property (!(apb_done && pwrite) // R17
        |=> $stable(st_q.f_m1) && $stable(st_q.k_m1))
        else $error("configuration changed without a write");
    a_ctrl_hold: assert property (!(apb_done && pwrite) // R17
        |=> $stable(st_q.ctrl.sub1) && $stable(st_q.ctrl.alwayson))
        else $error("control changed without a write");
    a_wr_unmapped: assert property (apb_done && pwrite && !hit // R17
        |=> $stable(st_q.f_m1) && $stable(st_q.ctrl.sub1))
        else $error("unmapped write changed a register");

    c_single_edge: cover property (edge_use && st_q.ctrl.singledet);
    c_both_bits: cover property (edge_use && st_q.ctrl.singledet && st_q.ctrl.alwayson);
    c_period_err: cover property ($rose(st_q.err));
    c_apb_read: cover property (apb_done && !pwrite && !st_q.pslverr);
    c_sub0_edge: cover property (sysref_edge && !st_q.ctrl.sub1);

endmodule : mfs_aligner

// *** include/mfs_pkg.sv ***
// Package: register map, field layout, reset values and state types of the multiframe aligner
package mfs_pkg;

    // Register byte offsets
    localparam logic [11:0] MFS_CTRL_OFS = 12'h0000;
    localparam logic [11:0] MFS_CFG_OFS = 12'h0004;
    localparam logic [11:0] MFS_STATUS_OFS = 12'h0008;

    // Control register fields
    localparam int MFS_CTRL_SINGLE_BIT = 0;
    localparam int MFS_CTRL_ALWAYS_BIT = 1;
    localparam int MFS_CTRL_SUB1_BIT = 2;

    // Configuration fields: F minus one and K minus one
    localparam int MFS_CFG_F_LSB = 0;
    localparam int MFS_CFG_K_LSB = 8;

    // Status fields
    localparam int MFS_STAT_ERR_BIT = 0;
    localparam int MFS_STAT_ALIGNED_BIT = 1;
    localparam int MFS_STAT_CNT_LSB = 8;

    // Datapath octets per link clock, divides F x K
    localparam int MFS_OCTETS_PER_CLK = 4;

    // Reset values: F = 2, K = 16
    localparam logic [7:0] MFS_F_M1_RST = 8'h01;
    localparam logic [4:0] MFS_K_M1_RST = 5'h0f;

    typedef struct packed {
        logic sub1;
        logic alwayson;
        logic singledet;
    } mfs_ctrl_type;

    typedef struct packed {
        logic [2:0] sync;
        logic lvl;
        mfs_ctrl_type ctrl;
        logic [7:0] f_m1;
        logic [4:0] k_m1;
        logic [10:0] cnt;
        logic aligned;
        logic err;
        logic boundary;
        logic cgs_hold;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } mfs_state_type;

    localparam mfs_state_type MFS_STATE_RST = '{
        sync: 3'h0, lvl: 1'b0, ctrl: '{sub1: 1'b1, alwayson: 1'b0, singledet: 1'b0},
        f_m1: MFS_F_M1_RST, k_m1: MFS_K_M1_RST, cnt: 11'h000, aligned: 1'b0,
        err: 1'b0, boundary: 1'b0, cgs_hold: 1'b0, pready: 1'b0, pslverr: 1'b0,
        prdata: 32'h0000_0000
    };

endpackage : mfs_pkg

// *** verif/mfs_sysref_gen.sv ***
// SYSREF source model: periodic pulses launched on the link clock
`timescale 1ns/1ps
module mfs_sysref_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [11:0] period,
    output logic sysref
);
    logic [11:0] ph_q;

    // Two-cycle pulse per period; low while idle so no stray edge appears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q <= 12'h000;
            sysref <= 1'b0;
        end else if (!run) begin
            ph_q <= 12'h000;
            sysref <= 1'b0;
        end else begin
            ph_q <= (ph_q == period - 12'h001) ? 12'h000 : ph_q + 12'h001;
            sysref <= (ph_q < 12'h002);
        end
    end
endmodule : mfs_sysref_gen

// *** verif/test_mfs_aligner.sv ***
// Self-checking bench for the multiframe counter and SYSREF alignment
`timescale 1ns/1ps
module test_mfs_aligner;
    typedef struct {
        logic [31:0] ctrl;
        logic [31:0] cfg;
        int per;
        int gen;
        logic err;
        logic hold;
    } mfs_row_type;
    logic pclk, presetn, psel, penable, pwrite, run, pready, pslverr, er;
    logic mf_boundary, cgs_hold, period_err, sysref;
    logic [11:0] paddr, gper;
    logic [31:0] pwdata, prdata, rd;
    logic [10:0] mf_count, c;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    // Legal F and K only; SYSREF period a multiple of the multiframe except one row
    mfs_row_type rows [7] = '{
        '{32'h0000_0006, 32'h0000_0f01, 8, 16, 1'b0, 1'b0},
        '{32'h0000_0006, 32'h0000_0f03, 16, 16, 1'b0, 1'b0},
        '{32'h0000_0006, 32'h0000_1f00, 8, 24, 1'b0, 1'b0},
        '{32'h0000_0006, 32'h0000_0702, 6, 12, 1'b0, 1'b0},
        '{32'h0000_0006, 32'h0000_1f07, 64, 64, 1'b0, 1'b0},
        '{32'h0000_0006, 32'h0000_1300, 5, 11, 1'b1, 1'b0},
        '{32'h0000_0007, 32'h0000_0f01, 8, 16, 1'b0, 1'b1}};

    mfs_aligner mfs_aligner_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sysref(sysref), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mf_count(mf_count), .mf_boundary(mf_boundary),
        .cgs_hold(cgs_hold), .period_err(period_err));
    mfs_sysref_gen mfs_sysref_gen_i (.pclk(pclk), .presetn(presetn), .run(run),
        .period(gper), .sysref(sysref));

    // 50 MHz link clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task end_of_test;
        if (err_total == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    // Hang guard, well above the expected run length
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task step(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : step

    // APB transfer; only the hang guard bounds the wait for pready
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            #1;
        end while (pready !== 1'b1);
        chk(pready, 1'b1);
        rd = prdata;
        er = pslverr;
        // Completing edge samples pready high; release only after it
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    initial begin
        {psel, penable, pwrite, run, presetn} = 5'h00;
        paddr = 12'h000;
        gper = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, mfs_pkg::MFS_CTRL_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0004);
        apb(1'b0, mfs_pkg::MFS_CFG_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0f01);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk(er, 1'b1);
        chk(rd, 32'h0000_0000);
        // Ordinary cases: align, count, wrap, period check
        foreach (rows[i]) begin
            apb(1'b1, mfs_pkg::MFS_CFG_OFS, rows[i].cfg);
            apb(1'b1, mfs_pkg::MFS_CTRL_OFS, rows[i].ctrl);
            step(2);
            chk(cgs_hold, rows[i].hold);
            @(posedge pclk);
            run <= 1'b1;
            gper <= 12'(rows[i].gen);
            step(5);
            chk(mf_count, 11'h000);
            step(rows[i].per - 1);
            chk(mf_count, 11'(rows[i].per - 1));
            step(1);
            chk(mf_count, 11'h000);
            apb(1'b1, mfs_pkg::MFS_STATUS_OFS, 32'h0000_0001);
            step(2 * rows[i].gen);
            chk(cgs_hold, 1'b0);
            @(posedge pclk);
            run <= 1'b0;
            step(4);
            apb(1'b0, mfs_pkg::MFS_STATUS_OFS, 32'h0000_0000);
            chk(rd[1:0], {1'b1, rows[i].err});
            apb(1'b1, mfs_pkg::MFS_STATUS_OFS, 32'h0000_0001);
            step(1);
            chk(period_err, 1'b0);
        end
        // One-shot: second edge off the boundary must not realign
        apb(1'b1, mfs_pkg::MFS_CTRL_OFS, 32'h0000_0005);
        @(posedge pclk);
        run <= 1'b1;
        gper <= 12'h02b;
        step(5);
        chk(mf_count, 11'h000);
        step(43);
        chk(mf_count, 11'h003);
        chk(cgs_hold, 1'b0);
        apb(1'b0, mfs_pkg::MFS_CTRL_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0004);
        // Subclass 0: SYSREF ignored, counter free-runs
        @(posedge pclk);
        run <= 1'b0;
        step(4);
        apb(1'b1, mfs_pkg::MFS_CTRL_OFS, 32'h0000_0002);
        @(posedge pclk);
        run <= 1'b1;
        gper <= 12'h00d;
        step(5);
        c = mf_count;
        step(13);
        chk(mf_count, 11'((c + 11'd13) % 11'd8));
        chk({cgs_hold, period_err}, 2'b00);
        end_of_test();
    end
endmodule : test_mfs_aligner
